// ===== rtl/tag_block_write_access_control.sv
// Purpose: Write access control for the tag's 32-bit block memory.
// Assumes: Frame decode, CRC and the tag state machine sit outside and hand over
//   checked block read and write commands; power_good comes from the field detector.
// Notes: The user array is behavioural; field loss aborts any running write.
// Summary of operation
// RULE1 - Boolean blocks store old AND new data
// RULE2 - All-zero Boolean block refuses further writes
// RULE3 - Reload bits change on block 6 arms erase
// RULE4 - Armed erase lasts until power loss or select; armed_ff clears only on reset_n or select_seen, not when power_good drops
// RULE5 - Counter accepts only strictly lower values
// RULE6 - Counter resets: 5 is FFFFFFFE, 6 all ones
// RULE7 - Power loss mid-programming keeps old counter
// RULE8 - User block write replaces whole word
// RULE9 - Block 255 bits 31:24 lock blocks 7-15
// RULE10 - Locks are permanent; locked blocks refuse writes
// RULE11 - System block ANDs data, empty refuses writes
// RULE12 - Mask option makes bits 7:0 the id
// RULE13 - All blocks readable; reader uses block commands
// RULE14 - Whole 32-bit words, 8-bit block address
// RULE15 - Rejected commands get no answer at all
// RULE16 - Refused writes change nothing anywhere
`timescale 1ns/10ps
module tag_block_write_access_control #(
  parameter int PROG_CYCLES_P = tag_access_pkg::PROG_CYCLES
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire tag_access_pkg::block_cmd_t cmd,
  output logic cmd_ready,
  output tag_access_pkg::block_rsp_t rsp,
  input wire logic select_seen,
  input wire logic power_good,
  input wire logic fixed_id_option,
  input wire logic [7:0] random_id,
  output logic [7:0] tag_select_id,
  output logic reload_armed
);
  import tag_access_pkg::*;

  // Lock decode for blocks 7 to 15; bit 24 covers the pair 7 and 8
  function automatic logic block_locked(input logic [7:0] a, input logic [31:0] sys);
    logic [7:0] locks;
    logic hit;
    locks = sys[31:LOCK_LSB];
    hit = 1'b0;
    if (a >= ADDR_USER_FIRST && a <= ADDR_LOCK_PAIR_LAST) begin
      hit = !locks[0]; // RULE9
    end else if (a > ADDR_LOCK_PAIR_LAST && a <= ADDR_LOCKABLE_LAST) begin
      hit = !locks[3'(a - ADDR_LOCK_PAIR_LAST)]; // RULE9
    end
    return hit;
  endfunction

  logic pg_meta_ff;
  logic pg_sync_ff;
  logic [31:0] mem [0:MEM_WORDS-1];
  logic [31:0] bool_ff [0:4];
  logic [31:0] cnt_a_ff;
  logic [31:0] cnt_reload_ff;
  logic [31:0] sys_ff;
  logic armed_ff;
  logic fixed_opt_meta_ff;
  logic fixed_opt_ff;
  logic [7:0] stage_addr_ff;
  logic [31:0] stage_data_ff;
  logic stage_rearm_ff;
  block_rsp_t rsp_ff;
  logic busy;
  logic commit;
  logic start;
  logic [31:0] old_word;
  logic [31:0] nxt_word;
  logic accept;
  logic rearm;

  // Field detector is asynchronous to the carrier clock
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pg_meta_ff <= 1'b0;
      pg_sync_ff <= 1'b0;
    end else if (clk_en) begin
      pg_meta_ff <= power_good;
      pg_sync_ff <= pg_meta_ff;
    end
  end

  // Mask option is a pad strap, so it passes two flops like power_good
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      fixed_opt_meta_ff <= 1'b0;
      fixed_opt_ff <= 1'b0;
    end else if (clk_en) begin
      fixed_opt_meta_ff <= fixed_id_option;
      fixed_opt_ff <= fixed_opt_meta_ff;
    end
  end

  always_comb begin
    old_word = WORD_EMPTY;
    if (cmd.addr <= ADDR_BOOL_LAST) begin
      old_word = bool_ff[3'(cmd.addr)];
    end else if (cmd.addr == ADDR_CNT_A) begin
      old_word = cnt_a_ff;
    end else if (cmd.addr == ADDR_CNT_RELOAD) begin
      old_word = cnt_reload_ff;
    end else if (cmd.addr <= ADDR_USER_LAST) begin
      old_word = mem[7'(cmd.addr)];
    end else if (cmd.addr == ADDR_SYSTEM) begin
      old_word = sys_ff;
    end
  end

  always_comb begin
    nxt_word = cmd.data; // RULE14
    accept = 1'b0;
    rearm = 1'b0;
    if (cmd.addr <= ADDR_BOOL_LAST) begin
      if (armed_ff) begin
        accept = 1'b1; // RULE4
      end else begin
        accept = (old_word != WORD_EMPTY); // RULE2
        nxt_word = old_word & cmd.data; // RULE1
      end
    end else if (cmd.addr == ADDR_CNT_A || cmd.addr == ADDR_CNT_RELOAD) begin
      accept = (cmd.data < old_word); // RULE5
      rearm = (cmd.addr == ADDR_CNT_RELOAD) &&
              (cmd.data[RELOAD_MSB:RELOAD_LSB] != old_word[RELOAD_MSB:RELOAD_LSB]); // RULE3
    end else if (cmd.addr <= ADDR_USER_LAST) begin
      accept = !block_locked(cmd.addr, sys_ff); // RULE10
    end else if (cmd.addr == ADDR_SYSTEM) begin
      accept = (old_word != WORD_EMPTY); // RULE11
      nxt_word = old_word & cmd.data; // RULE11
    end
  end

  // The commit cycle blocks commands too, so no check reads a word about to change
  assign cmd_ready = !busy && !commit;
  assign start = cmd.valid && cmd.write && cmd_ready && accept; // RULE16

  // Data is held aside and only lands in the array on a clean commit
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      stage_addr_ff <= '0;
      stage_data_ff <= '0;
      stage_rearm_ff <= 1'b0;
    end else if (clk_en && start) begin
      stage_addr_ff <= cmd.addr;
      stage_data_ff <= nxt_word;
      stage_rearm_ff <= rearm;
    end
  end

  prog_cycle_timer #(.CYCLES(PROG_CYCLES_P)) u_prog (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .start(start),
    .power_ok(pg_sync_ff),
    .busy(busy),
    .commit(commit)
  );

  // Counters take their new value only at commit, so tearing leaves the old one
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cnt_a_ff <= CNT_A_RESET; // RULE6
      cnt_reload_ff <= CNT_RELOAD_RESET; // RULE6
    end else if (clk_en && commit) begin
      if (stage_addr_ff == ADDR_CNT_A) begin
        cnt_a_ff <= stage_data_ff; // RULE7
      end
      if (stage_addr_ff == ADDR_CNT_RELOAD) begin
        cnt_reload_ff <= stage_data_ff; // RULE7
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi <= 4; gi++) begin : g_bool
      always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
          bool_ff[gi] <= OTP_RESET;
        end else if (clk_en && commit && stage_addr_ff == 8'(gi)) begin
          bool_ff[gi] <= stage_data_ff; // RULE1
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sys_ff <= OTP_RESET;
    end else if (clk_en && commit && stage_addr_ff == ADDR_SYSTEM) begin
      sys_ff <= stage_data_ff; // RULE11
    end
  end

  // User array is not reset: it stands for nonvolatile storage
  always_ff @(posedge clk_sys) begin
    if (clk_en && commit && stage_addr_ff >= ADDR_USER_FIRST && stage_addr_ff <= ADDR_USER_LAST) begin
      mem[7'(stage_addr_ff)] <= stage_data_ff; // RULE8
    end
  end

  // Arming wins over a select in the same cycle
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      armed_ff <= 1'b0; // RULE4
    end else if (clk_en) begin
      if (commit && stage_rearm_ff) begin
        armed_ff <= 1'b1; // RULE3
      end else if (select_seen) begin
        armed_ff <= 1'b0; // RULE4
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rsp_ff <= '0;
    end else if (clk_en) begin
      rsp_ff.rd_valid <= 1'b0;
      rsp_ff.wr_done <= commit; // RULE15
      if (cmd.valid && !cmd.write && cmd_ready &&
          (cmd.addr <= ADDR_USER_LAST || cmd.addr == ADDR_SYSTEM)) begin
        rsp_ff.rd_valid <= 1'b1; // RULE13
        rsp_ff.data <= old_word; // RULE13
      end
    end
  end

  assign rsp = rsp_ff;
  assign tag_select_id = fixed_opt_ff ? sys_ff[ID_MSB:0] : random_id; // RULE12
  assign reload_armed = armed_ff;
endmodule

// ===== rtl/tag_access_pkg.sv
// Purpose: Shared constants and types for the tag block write access control.
// Assumes: One 10 MHz clock; block addresses are 8 bits, data words 32 bits.
// Notes: Reset values of the counters and the one-time areas live here.
package tag_access_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] ADDR_BOOL_LAST = 8'h04;
  localparam logic [7:0] ADDR_CNT_A = 8'h05;
  localparam logic [7:0] ADDR_CNT_RELOAD = 8'h06;
  localparam logic [7:0] ADDR_USER_FIRST = 8'h07;
  localparam logic [7:0] ADDR_USER_LAST = 8'h7f;
  localparam logic [7:0] ADDR_SYSTEM = 8'hff;
  localparam logic [7:0] ADDR_LOCK_PAIR_LAST = 8'h08;
  localparam logic [7:0] ADDR_LOCKABLE_LAST = 8'h0f;
  localparam int MEM_WORDS = 128;
  localparam int LOCK_LSB = 24;
  localparam int RELOAD_LSB = 21;
  localparam int RELOAD_MSB = 31;
  localparam int ID_MSB = 7;
  localparam logic [31:0] CNT_A_RESET = 32'hfffffffe;
  localparam logic [31:0] CNT_RELOAD_RESET = 32'hffffffff;
  localparam logic [31:0] OTP_RESET = 32'hffffffff;
  localparam logic [31:0] WORD_EMPTY = 32'h00000000;
  // Self-timed programming time and its cycle count at 10 MHz
  localparam int PROG_TIME_US = 5000;
  localparam int CLK_MHZ = 10;
  localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
  localparam int PROG_CNT_W = 16;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
    logic [31:0] data;
  } block_cmd_t;

  typedef struct packed {
    logic rd_valid;
    logic wr_done;
    logic [31:0] data;
  } block_rsp_t;
endpackage

// ===== rtl/prog_cycle_timer.sv
// Purpose: Times one self-timed programming cycle and reports commit or abort.
// Assumes: power_ok is already synchronised to clk_sys.
// Notes: A commit pulse is only issued if power stayed good for the whole cycle.
`timescale 1ns/10ps
module prog_cycle_timer #(
  parameter int CYCLES = tag_access_pkg::PROG_CYCLES
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic start,
  input wire logic power_ok,
  output logic busy,
  output logic commit
);
  import tag_access_pkg::*;
  localparam logic [PROG_CNT_W-1:0] LAST = PROG_CNT_W'(CYCLES - 1);
  logic [PROG_CNT_W-1:0] cnt_ff;
  logic busy_ff;
  logic commit_ff;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      busy_ff <= 1'b0;
      cnt_ff <= '0;
    end else if (clk_en) begin
      if (busy_ff && !power_ok) begin
        busy_ff <= 1'b0; // RULE7
      end else if (busy_ff) begin
        if (cnt_ff == LAST) begin
          busy_ff <= 1'b0;
        end
        cnt_ff <= cnt_ff + 1'b1;
      end else if (start) begin
        busy_ff <= 1'b1;
        cnt_ff <= '0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      commit_ff <= 1'b0;
    end else if (clk_en) begin
      commit_ff <= busy_ff && power_ok && (cnt_ff == LAST);
    end
  end

  assign busy = busy_ff;
  assign commit = commit_ff;
endmodule

// ===== verification/tag_access_properties.sv
// Purpose: Port-level timing checks of the block access control.
// Assumes: Bound to the top module; clk_en is in the antecedents of the command and select checks only.
// Notes: Full busy length is only checked after four cycles of good power up to the command, since loss aborts.
`timescale 1ns/10ps
module tag_access_properties #(
  parameter int PROG_CYCLES_P = 8
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire tag_access_pkg::block_cmd_t cmd,
  input wire logic cmd_ready,
  input wire tag_access_pkg::block_rsp_t rsp,
  input wire logic select_seen,
  input wire logic power_good,
  input wire logic fixed_id_option,
  input wire logic [7:0] random_id,
  input wire logic [7:0] tag_select_id,
  input wire logic reload_armed
);
  import tag_access_pkg::*;
  logic take;
  logic hole;
  assign take = cmd.valid && cmd_ready && clk_en;
  assign hole = cmd.addr > ADDR_USER_LAST && cmd.addr != ADDR_SYSTEM;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  property p_rd_ans; take && !cmd.write && !hole |=> rsp.rd_valid; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
  property p_no_ans; take && !cmd.write && hole |=> !rsp.rd_valid; endproperty
  a_no_ans: assert property (p_no_ans) else $error("unmapped read answered");
  property p_hole_wr; take && cmd.write && hole |=> cmd_ready && !rsp.wr_done; endproperty
  a_hole_wr: assert property (p_hole_wr) else $error("unmapped write started");
  property p_user_wr;
    power_good[*4] ##0 (take && cmd.write && cmd.addr > ADDR_LOCKABLE_LAST && !hole)
      |=> !cmd_ready ##PROG_CYCLES_P !cmd_ready ##1 cmd_ready;
  endproperty
  a_user_wr: assert property (p_user_wr) else $error("user write busy time wrong");
  property p_wr_done; rsp.wr_done |-> cmd_ready && !$past(cmd_ready); endproperty
  a_wr_done: assert property (p_wr_done) else $error("write done without busy end");
  property p_rd_hold; $changed(rsp.data) |-> rsp.rd_valid; endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved alone");
  property p_sel_clr; select_seen && cmd_ready && clk_en |=> !reload_armed; endproperty
  a_sel_clr: assert property (p_sel_clr) else $error("select left erase armed");
  property p_arm_keep; power_good[*4] ##0 (reload_armed && !select_seen) |=> reload_armed; endproperty
  a_arm_keep: assert property (p_arm_keep) else $error("erase phase dropped");
  property p_arm_rise; $rose(reload_armed) |-> rsp.wr_done; endproperty
  a_arm_rise: assert property (p_arm_rise) else $error("arming not at commit");
  property p_id;
    !fixed_id_option && !$past(fixed_id_option) && !$past(fixed_id_option, 2) |-> tag_select_id == random_id;
  endproperty
  a_id: assert property (p_id) else $error("random id not passed");
  c_write: cover property (take && cmd.write ##1 !cmd_ready);
  c_arm: cover property ($rose(reload_armed));
  c_read: cover property (rsp.rd_valid);
endmodule

bind tag_block_write_access_control tag_access_properties #(.PROG_CYCLES_P(PROG_CYCLES_P)) chk (
  .clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en), .cmd(cmd), .cmd_ready(cmd_ready),
  .rsp(rsp), .select_seen(select_seen), .power_good(power_good), .fixed_id_option(fixed_id_option),
  .random_id(random_id), .tag_select_id(tag_select_id), .reload_armed(reload_armed));

// ===== verification/block_reader.sv
// Purpose: Reader model issuing whole-word block reads and writes.
// Assumes: One command at a time; held until taken.
// Notes: Released lines show the inverse of the last value, never a stale copy.
`timescale 1ns/10ps
module block_reader #(
  parameter int PROG_CYCLES_P = 8
) (
  input wire logic clk_sys,
  output tag_access_pkg::block_cmd_t cmd,
  input wire logic cmd_ready,
  input wire tag_access_pkg::block_rsp_t rsp
);
  import tag_access_pkg::*;
  initial cmd = '0;
  // Refused commands get no answer, so the wait is bounded
  task automatic access(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic got);
    int n;
    got = 1'b0;
    q = WORD_EMPTY;
    @(posedge clk_sys);
    while (cmd_ready !== 1'b1) @(posedge clk_sys);
    cmd <= '{1'b1, wr, a, d};
    @(posedge clk_sys);
    while (cmd_ready !== 1'b1) @(posedge clk_sys);
    cmd <= '{1'b0, ~wr, ~a, ~d};
    for (n = 0; n < PROG_CYCLES_P + 4 && !got; n++) begin
      #1;
      got = wr ? rsp.wr_done : rsp.rd_valid;
      q = rsp.data;
      if (!got) @(posedge clk_sys);
    end
  endtask
endmodule

// ===== verification/tb.sv
// Purpose: Self-checking bench for the block write access control.
// Assumes: Short programming count; clk_en dropped once in mid-write.
// Notes: Each row does an optional select, an optional write, then a read back.
`timescale 1ns/10ps
module tb;
  import tag_access_pkg::*;
  localparam int PROG = 8;
  typedef struct packed {logic sel; logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] q; logic arm;} row_t;
  logic clk_sys, reset_n, select_seen, power_good, fixed_id_option, cmd_ready, reload_armed, got;
  logic clk_en;
  logic [7:0] random_id;
  logic [7:0] tag_select_id;
  logic [31:0] q;
  block_cmd_t cmd;
  block_rsp_t rsp;
  int fails = 0;
  int checks = 0;
  int cyc = 0;
  row_t rows [0:20] = '{
    '{1'b0, 1'b1, 8'h00, 32'hffff00ff, 32'hffff00ff, 1'b0},
    '{1'b0, 1'b1, 8'h00, 32'h0f0f0f0f, 32'h0f0f000f, 1'b0},
    '{1'b0, 1'b1, 8'h01, 32'h00000000, 32'h00000000, 1'b0},
    '{1'b0, 1'b1, 8'h01, 32'hffffffff, 32'h00000000, 1'b0},
    '{1'b0, 1'b0, 8'h05, 32'h0, 32'hfffffffe, 1'b0},
    '{1'b0, 1'b0, 8'h06, 32'h0, 32'hffffffff, 1'b0},
    '{1'b0, 1'b1, 8'h05, 32'hfffffffe, 32'hfffffffe, 1'b0},
    '{1'b0, 1'b1, 8'h05, 32'h00000010, 32'h00000010, 1'b0},
    '{1'b0, 1'b1, 8'h05, 32'h00000011, 32'h00000010, 1'b0},
    '{1'b0, 1'b1, 8'h14, 32'h12345678, 32'h12345678, 1'b0},
    '{1'b0, 1'b1, 8'h14, 32'h00ff00ff, 32'h00ff00ff, 1'b0},
    '{1'b0, 1'b1, 8'h09, 32'haaaa5555, 32'haaaa5555, 1'b0},
    '{1'b0, 1'b1, 8'h08, 32'h00000001, 32'h00000001, 1'b0},
    '{1'b0, 1'b1, 8'hff, 32'hfdffffff, 32'hfdffffff, 1'b0},
    '{1'b0, 1'b1, 8'h09, 32'h00000000, 32'haaaa5555, 1'b0},
    '{1'b0, 1'b1, 8'hff, 32'hfeffffff, 32'hfcffffff, 1'b0},
    '{1'b0, 1'b1, 8'h08, 32'h00000002, 32'h00000001, 1'b0},
    '{1'b0, 1'b1, 8'h06, 32'hffdfffff, 32'hffdfffff, 1'b1},
    '{1'b0, 1'b1, 8'h01, 32'h0000ffff, 32'h0000ffff, 1'b1},
    '{1'b1, 1'b1, 8'h01, 32'hffff0f0f, 32'h00000f0f, 1'b0},
    '{1'b0, 1'b1, 8'h06, 32'hffdffff0, 32'hffdffff0, 1'b0}};
  tag_block_write_access_control #(.PROG_CYCLES_P(PROG)) DUT (.clk_sys(clk_sys), .reset_n(reset_n),
    .clk_en(clk_en), .cmd(cmd), .cmd_ready(cmd_ready), .rsp(rsp), .select_seen(select_seen),
    .power_good(power_good), .fixed_id_option(fixed_id_option), .random_id(random_id),
    .tag_select_id(tag_select_id), .reload_armed(reload_armed));
  block_reader #(.PROG_CYCLES_P(PROG)) rdr (.clk_sys(clk_sys), .cmd(cmd), .cmd_ready(cmd_ready), .rsp(rsp));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // Generous ceiling: the whole run needs well under a thousand cycles
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails++;
      give_verdict;
    end
  end
  initial begin
    reset_n = 1'b0;
    clk_en = 1'b1;
    select_seen = 1'b0;
    power_good = 1'b1;
    fixed_id_option = 1'b0;
    random_id = 8'hc3;
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    #1;
    chk("ready", 32'h1, {31'h0, cmd_ready});
    chk("armed", 32'h0, {31'h0, reload_armed});
    chk("id", {24'h0, random_id}, {24'h0, tag_select_id});
    repeat (3) @(posedge clk_sys);
    $display("test reset done");
    for (int i = 0; i < 21; i++) begin
      @(posedge clk_sys);
      select_seen <= rows[i].sel;
      @(posedge clk_sys);
      select_seen <= 1'b0;
      if (rows[i].wr) rdr.access(1'b1, rows[i].a, rows[i].d, q, got);
      rdr.access(1'b0, rows[i].a, WORD_EMPTY, q, got);
      chk("block", rows[i].q, q);
      chk("armed", {31'h0, rows[i].arm}, {31'h0, reload_armed});
    end
    $display("test rows done");
    rdr.access(1'b1, 8'h80, 32'h5a5a5a5a, q, got);
    chk("hole write", 32'h0, {31'h0, got});
    rdr.access(1'b0, 8'h80, WORD_EMPTY, q, got);
    chk("hole read", 32'h0, {31'h0, got});
    $display("test unmapped done");
    @(posedge clk_sys);
    fixed_id_option <= 1'b1;
    rdr.access(1'b1, ADDR_SYSTEM, 32'hfcffff5a, q, got);
    repeat (2) @(posedge clk_sys);
    #1;
    chk("fixed id", 32'h5a, {24'h0, tag_select_id});
    $display("test fixed id done");
    fork
      rdr.access(1'b1, ADDR_CNT_RELOAD, 32'h00000100, q, got);
      begin
        repeat (4) @(posedge clk_sys);
        power_good <= 1'b0;
        repeat (3) @(posedge clk_sys);
        power_good <= 1'b1;
      end
    join
    chk("torn done", 32'h0, {31'h0, got});
    repeat (4) @(posedge clk_sys);
    rdr.access(1'b0, ADDR_CNT_RELOAD, WORD_EMPTY, q, got);
    chk("torn value", 32'hffdffff0, q);
    chk("torn armed", 32'h0, {31'h0, reload_armed});
    $display("test power loss done");
    // Two frozen cycles stretch the write, so the commit cycle is still running twelve edges in
    fork
      rdr.access(1'b1, 8'h0a, 32'h600dcafe, q, got);
      begin
        repeat (4) @(posedge clk_sys);
        clk_en <= 1'b0;
        repeat (2) @(posedge clk_sys);
        clk_en <= 1'b1;
        repeat (6) @(posedge clk_sys);
        #1;
        chk("frozen busy", 32'h0, {31'h0, cmd_ready});
      end
    join
    chk("frozen done", 32'h1, {31'h0, got});
    rdr.access(1'b0, 8'h0a, WORD_EMPTY, q, got);
    chk("frozen value", 32'h600dcafe, q);
    $display("test clock enable done");
    give_verdict;
  end
endmodule
